// file: design/art_timer.v
`timescale 1ns/10ps
`include "art_defines.vh"
// Sixteen-bit auto-reload timer with split mode and oscillator capture.
// Registers sit on a simple special-function-register port: one-cycle
// write strobe, combinational address with registered read data.
module art_timer (
    input  wire       clk_in,
    input  wire       rst_in,
    input  wire [7:0] sfr_addr_in,
    input  wire [7:0] sfr_wdata_in,
    input  wire       sfr_wr_in,
    input  wire       sfr_rd_in,
    input  wire       timer_irq_enable_in,
    input  wire       high_byte_clock_pick_in,
    input  wire       low_byte_clock_pick_in,
    input  wire       ext_clk_in,
    input  wire       lfo_in,
    output reg  [7:0] sfr_rdata_out,
    output reg        irq_out,
    output reg  [7:0] counter_low_out,
    output reg  [7:0] counter_high_out
);
    reg  [7:0] ctrl_ff;
    reg  [7:0] reload_low_ff;
    reg  [7:0] reload_high_ff;
    reg  [7:0] counter_low_ff;
    reg  [7:0] counter_high_ff;
    reg        lfo_s1_ff;
    reg        lfo_s2_ff;
    reg        lfo_s3_ff;
    reg        cap_pend_ff;
    wire       core_tick;
    wire       ext_tick;

    wire run        = ctrl_ff[`ART_BIT_RUN];
    wire split      = ctrl_ff[`ART_BIT_SPLIT];
    wire ext_sel    = ctrl_ff[`ART_BIT_EXT_CLK];
    wire cap_en     = ctrl_ff[`ART_BIT_CAP_EN];

    function sel_tick;
        input pick;
        input use_ext;
        input ct;
        input et;
        begin
            sel_tick = (pick & use_ext) ? et : ct;
        end
    endfunction

    art_tick_gen u_tick (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .ext_clk_in    (ext_clk_in),
        .core_tick_out (core_tick),
        .ext_tick_out  (ext_tick)
    );

    // Per-byte pick chooses selected external clock or core timebase
    wire lo_tick = sel_tick(low_byte_clock_pick_in, ext_sel, core_tick, ext_tick);
    wire hi_tick = sel_tick(split ? high_byte_clock_pick_in : low_byte_clock_pick_in,
                            ext_sel, core_tick, ext_tick);

    // Counting enables; split low byte ignores run bit
    wire lo_en   = lo_tick & (split | run);
    wire lo_wrap = lo_en & (counter_low_ff == `ART_BYTE_MAX);
    wire hi_en   = split ? (hi_tick & run) : lo_wrap;
    wire hi_wrap = hi_en & (counter_high_ff == `ART_BYTE_MAX);

    // Oscillator falling edge, taken from synchronised copies only
    wire lfo_fall = lfo_s3_ff & ~lfo_s2_ff;
    wire cap_evt  = cap_en & lfo_fall;

    wire wr_ctrl = sfr_wr_in && (sfr_addr_in == `ART_ADDR_CTRL);
    wire wr_rll  = sfr_wr_in && (sfr_addr_in == `ART_ADDR_RLD_LO);
    wire wr_rlh  = sfr_wr_in && (sfr_addr_in == `ART_ADDR_RLD_HI);
    wire wr_cl   = sfr_wr_in && (sfr_addr_in == `ART_ADDR_CNT_LO);
    wire wr_ch   = sfr_wr_in && (sfr_addr_in == `ART_ADDR_CNT_HI);

    reg  [7:0] nxt_ctrl;
    reg  [7:0] nxt_rdata;

    // Control: software writes, hardware sets win over a clearing write
    always @* begin
        nxt_ctrl = ctrl_ff;
        if (wr_ctrl) begin
            nxt_ctrl = sfr_wdata_in & `ART_CTRL_WMASK;
        end
        if (hi_wrap) begin
            nxt_ctrl[`ART_BIT_HFLAG] = 1'b1;
        end
        if (lo_wrap) begin
            nxt_ctrl[`ART_BIT_LFLAG] = 1'b1;
        end
    end

    // Read mux; unmapped addresses read zero
    always @* begin
        if (sfr_addr_in == `ART_ADDR_CTRL) begin
            nxt_rdata = ctrl_ff;
        end else if (sfr_addr_in == `ART_ADDR_RLD_LO) begin
            nxt_rdata = reload_low_ff;
        end else if (sfr_addr_in == `ART_ADDR_RLD_HI) begin
            nxt_rdata = reload_high_ff;
        end else if (sfr_addr_in == `ART_ADDR_CNT_LO) begin
            nxt_rdata = counter_low_ff;
        end else if (sfr_addr_in == `ART_ADDR_CNT_HI) begin
            nxt_rdata = counter_high_ff;
        end else begin
            nxt_rdata = `ART_BYTE_ZERO;
        end
    end

    // Oscillator synchroniser
    always @(posedge clk_in) begin
        if (rst_in) begin
            lfo_s1_ff <= 1'b0;
            lfo_s2_ff <= 1'b0;
            lfo_s3_ff <= 1'b0;
        end else begin
            lfo_s1_ff <= lfo_in;
            lfo_s2_ff <= lfo_s1_ff;
            lfo_s3_ff <= lfo_s2_ff;
        end
    end

    // Registers and counters
    always @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_ff         <= `ART_CTRL_RESET;
            reload_low_ff   <= `ART_BYTE_ZERO;
            reload_high_ff  <= `ART_BYTE_ZERO;
            counter_low_ff  <= `ART_BYTE_ZERO;
            counter_high_ff <= `ART_BYTE_ZERO;
            cap_pend_ff     <= 1'b0;
            sfr_rdata_out   <= `ART_BYTE_ZERO;
        end else begin
            ctrl_ff <= nxt_ctrl;
            if (sfr_rd_in) begin
                sfr_rdata_out <= nxt_rdata;
            end
            // Capture overrides a same-cycle software reload write
            if (cap_evt) begin
                reload_low_ff  <= counter_low_ff;
                reload_high_ff <= counter_high_ff;
            end else begin
                if (wr_rll) begin
                    reload_low_ff <= sfr_wdata_in;
                end
                if (wr_rlh) begin
                    reload_high_ff <= sfr_wdata_in;
                end
            end
            // Low byte: reload on its own wrap in split mode, on full wrap
            // in 16-bit mode; otherwise it rolls on to zero with the carry
            if (wr_cl) begin
                counter_low_ff <= sfr_wdata_in;
            end else if (lo_wrap && (split || hi_wrap)) begin
                counter_low_ff <= reload_low_ff;
            end else if (lo_en) begin
                counter_low_ff <= counter_low_ff + 8'h01;
            end
            // High byte: in 16-bit mode both bytes reload at full wrap only
            if (wr_ch) begin
                counter_high_ff <= sfr_wdata_in;
            end else if (hi_wrap) begin
                counter_high_ff <= reload_high_ff;
            end else if (hi_en) begin
                counter_high_ff <= counter_high_ff + 8'h01;
            end
            // Capture request held until software clears capture enable
            if (!cap_en) begin
                cap_pend_ff <= 1'b0;
            end else if (cap_evt) begin
                cap_pend_ff <= 1'b1;
            end
        end
    end

    // Outputs mirror state one cycle later, all from flip-flops
    always @(posedge clk_in) begin
        if (rst_in) begin
            irq_out          <= 1'b0;
            counter_low_out  <= `ART_BYTE_ZERO;
            counter_high_out <= `ART_BYTE_ZERO;
        end else begin
            irq_out <= timer_irq_enable_in &
                       (ctrl_ff[`ART_BIT_HFLAG] |
                        (ctrl_ff[`ART_BIT_LFLAG] & ctrl_ff[`ART_BIT_LIRQ_EN]) |
                        cap_pend_ff);
            counter_low_out  <= counter_low_ff;
            counter_high_out <= counter_high_ff;
        end
    end
endmodule // art_timer

// file: common/art_defines.vh
// How it works
// - High byte wrap sets high overflow flag
// - Sixteen-bit mode flags low wrap and full wrap
// - High flag with interrupt enable requests interrupt
// - Flags cleared only by software write
// - Low byte wrap always sets low flag
// - Low flag requests interrupt when enabled
// - Oscillator falling edge captures count into reload
// - Capture event also requests interrupt
// - Split bit selects one 16 or two 8
// - Run bit starts and stops counting
// - Split mode: run gates high byte only
// - Clock select: core/12 or external/8
// - Per-byte picks choose external or core clock
// - Reload registers hold reload or captured bytes
// - Counter registers hold count bytes
`ifndef ART_DEFINES_VH
`define ART_DEFINES_VH
`define ART_ADDR_CTRL     8'h91
`define ART_ADDR_RLD_LO   8'h92
`define ART_ADDR_RLD_HI   8'h93
`define ART_ADDR_CNT_LO   8'h94
`define ART_ADDR_CNT_HI   8'h95
`define ART_CTRL_RESET    8'h00
`define ART_CTRL_WMASK    8'hFD
`define ART_BIT_HFLAG     7
`define ART_BIT_LFLAG     6
`define ART_BIT_LIRQ_EN   5
`define ART_BIT_CAP_EN    4
`define ART_BIT_SPLIT     3
`define ART_BIT_RUN       2
`define ART_BIT_EXT_CLK   0
`define ART_CORE_DIV      4'hC
`define ART_EXT_DIV       4'h8
`define ART_BYTE_MAX      8'hFF
`define ART_BYTE_ZERO     8'h00
`endif

// file: design/art_tick_gen.v
`timescale 1ns/10ps
`include "art_defines.vh"
// Timebase: core clock divided by 12 and resynchronised external clock by 8
module art_tick_gen (
    input  wire       clk_in,
    input  wire       rst_in,
    input  wire       ext_clk_in,
    output reg        core_tick_out,
    output reg        ext_tick_out
);
    reg  [3:0] core_cnt_ff;
    reg  [3:0] ext_cnt_ff;
    reg        ext_s1_ff;
    reg        ext_s2_ff;
    reg        ext_s3_ff;
    wire       ext_rise = ext_s2_ff & ~ext_s3_ff;

    // Two-stage sync; first stage read only by the second
    always @(posedge clk_in) begin
        if (rst_in) begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_s3_ff <= 1'b0;
        end else begin
            ext_s1_ff <= ext_clk_in;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
        end
    end

    // Dividers emit one-cycle enables
    always @(posedge clk_in) begin
        if (rst_in) begin
            core_cnt_ff   <= 4'h0;
            ext_cnt_ff    <= 4'h0;
            core_tick_out <= 1'b0;
            ext_tick_out  <= 1'b0;
        end else begin
            core_tick_out <= (core_cnt_ff == `ART_CORE_DIV - 4'h1);
            core_cnt_ff   <= (core_cnt_ff == `ART_CORE_DIV - 4'h1) ? 4'h0 : core_cnt_ff + 4'h1;
            ext_tick_out  <= 1'b0;
            if (ext_rise) begin
                ext_tick_out <= (ext_cnt_ff == `ART_EXT_DIV - 4'h1);
                ext_cnt_ff   <= (ext_cnt_ff == `ART_EXT_DIV - 4'h1) ? 4'h0 : ext_cnt_ff + 4'h1;
            end
        end
    end
endmodule // art_tick_gen

// file: tb/art_timer_monitor.sv
`timescale 1ns/10ps
// Port-level watcher; control bits are shadowed from software writes
module art_timer_monitor (
    input logic       clk_in,
    input logic       rst_in,
    input logic [7:0] sfr_addr_in,
    input logic [7:0] sfr_wdata_in,
    input logic       sfr_wr_in,
    input logic       sfr_rd_in,
    input logic       timer_irq_enable_in,
    input logic       irq_out,
    input logic [7:0] counter_low_out,
    input logic [7:0] counter_high_out,
    input logic [7:0] sfr_rdata_out
);
    logic [7:0]  ctrl_ff;
    logic [15:0] wr_hist_ff;
    logic [3:0]  since_ff;
    // Quiet: no write for 16 cycles, so mode switches cannot skew pacing
    wire         quiet = !sfr_wr_in && wr_hist_ff == 16'h0000;
    // Hardware only sets flags, so software writes give the mode bits
    always @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_ff    <= 8'h00;
            wr_hist_ff <= 16'h0000;
            since_ff   <= 4'h0;
        end else begin
            if (sfr_wr_in && sfr_addr_in == 8'h91) ctrl_ff <= sfr_wdata_in;
            wr_hist_ff <= {wr_hist_ff[14:0], sfr_wr_in};
            since_ff   <= $changed(counter_low_out) ? 4'h0 :
                          (since_ff == 4'hF) ? 4'hF : since_ff + 4'h1;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_rd_low; sfr_rd_in && sfr_addr_in == 8'h94 |=> sfr_rdata_out == counter_low_out;
    endproperty
    a_rd_low: assert property (p_rd_low) else $error("low count read differs");
    property p_stop; !ctrl_ff[2] && !ctrl_ff[3] && quiet |=> $stable(counter_low_out); endproperty
    a_stop: assert property (p_stop) else $error("count moved while stopped");
    property p_split; !ctrl_ff[2] && ctrl_ff[3] && quiet |=> $stable(counter_high_out); endproperty
    a_split: assert property (p_split) else $error("split high byte moved");
    property p_full; !ctrl_ff[3] && quiet && $changed(counter_high_out)
        |-> $past(counter_low_out) == 8'hFF; endproperty
    a_full: assert property (p_full) else $error("high byte moved without carry");
    property p_pace; quiet && !ctrl_ff[0] && $changed(counter_low_out) |-> since_ff >= 4'hB;
    endproperty
    a_pace: assert property (p_pace) else $error("core tick too fast");
    property p_mask; !timer_irq_enable_in |=> !irq_out; endproperty
    a_mask: assert property (p_mask) else $error("request while disabled");
    property p_hold; irq_out && timer_irq_enable_in && quiet |=> irq_out; endproperty
    a_hold: assert property (p_hold) else $error("request dropped by itself");
    property p_low; ctrl_ff[5] && timer_irq_enable_in && quiet && $changed(counter_low_out)
        && $past(counter_low_out) == 8'hFF |-> ##[0:2] irq_out; endproperty
    a_low: assert property (p_low) else $error("no request on low wrap");
    property p_high; timer_irq_enable_in && quiet && $changed(counter_high_out)
        && $past(counter_high_out) == 8'hFF |-> ##[0:2] irq_out; endproperty
    a_high: assert property (p_high) else $error("no request on high wrap");
    c_irq: cover property ($rose(irq_out));
    c_wrap: cover property ($changed(counter_high_out) && $past(counter_high_out) == 8'hFF);
    c_split: cover property (ctrl_ff[3] && $changed(counter_low_out));
endmodule // art_timer_monitor

// file: tb/art_timer_tb.sv
`timescale 1ns/10ps
module art_timer_tb;
    logic       clk_in = 1'b0, rst_in = 1'b1, wr = 1'b0, rd = 1'b0, irq_en = 1'b0;
    logic       hpick = 1'b1, lpick = 1'b1, ext_clk = 1'b0, lfo = 1'b1, irq;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, cnt_lo, cnt_hi;
    int         n_fail = 0, n_tests = 0, ext_div = 0;
    art_timer u_dut (.clk_in(clk_in), .rst_in(rst_in), .sfr_addr_in(addr), .sfr_wdata_in(wdata),
        .sfr_wr_in(wr), .sfr_rd_in(rd), .timer_irq_enable_in(irq_en),
        .high_byte_clock_pick_in(hpick), .low_byte_clock_pick_in(lpick), .ext_clk_in(ext_clk),
        .lfo_in(lfo), .sfr_rdata_out(rdata), .irq_out(irq), .counter_low_out(cnt_lo),
        .counter_high_out(cnt_hi));
    // External clock at a quarter of the core rate
    always @(posedge clk_in) begin
        ext_div <= ext_div + 1;
        if (ext_div[0]) ext_clk <= !ext_clk;
    end
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(string what, logic [7:0] a, logic [7:0] exp);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        @(posedge clk_in);
        #1 chk(what, exp, rdata);
    endtask
    // Bounded wait, sampled on the falling edge where outputs are settled
    task automatic wait_irq();
        for (int i = 0; i < 80 && irq !== 1'b1; i++) @(negedge clk_in);
        chk("irq raised", 8'h01, {7'h00, irq});
    endtask
    task automatic t_regs();
        rd_chk("ctrl reset", 8'h91, 8'h00);
        rd_chk("unmapped", 8'h90, 8'h00);
        wr_reg(8'h91, 8'h3B);
        rd_chk("ctrl reserved bit", 8'h91, 8'h39);
        wr_reg(8'h91, 8'h00);
    endtask
    task automatic t_wrap16();
        irq_en <= 1'b1;
        wr_reg(8'h92, 8'hFE);
        wr_reg(8'h93, 8'hAB);
        wr_reg(8'h94, 8'hFE);
        wr_reg(8'h95, 8'hFF);
        wr_reg(8'h91, 8'h04);
        wait_irq();
        rd_chk("both flags", 8'h91, 8'hC4);
        wr_reg(8'h91, 8'hC0);
        rd_chk("high reload", 8'h95, 8'hAB);
        rd_chk("low reload", 8'h94, 8'hFE);
        chk("irq held", 8'h01, {7'h00, irq});
        wr_reg(8'h91, 8'h00);
        repeat (2) @(posedge clk_in);
        #1 chk("irq cleared", 8'h00, {7'h00, irq});
    endtask
    task automatic t_low16();
        wr_reg(8'h95, 8'h10);
        wr_reg(8'h94, 8'hFF);
        wr_reg(8'h91, 8'h24);
        wait_irq();
        rd_chk("low flag only", 8'h91, 8'h64);
        wr_reg(8'h91, 8'h60);
        irq_en <= 1'b0;
        rd_chk("carry to high", 8'h95, 8'h11);
        rd_chk("low rolls to zero", 8'h94, 8'h00);
        chk("irq masked", 8'h00, {7'h00, irq});
        irq_en <= 1'b1;
        wr_reg(8'h91, 8'h00);
    endtask
    task automatic t_split();
        wr_reg(8'h95, 8'h50);
        wr_reg(8'h94, 8'hFF);
        wr_reg(8'h91, 8'h28);
        wait_irq();
        rd_chk("split flag", 8'h91, 8'h68);
        // Long quiet spell so the stopped high byte is watched for a while
        repeat (20) @(posedge clk_in);
        rd_chk("high held", 8'h95, 8'h50);
        chk("high out held", 8'h50, cnt_hi);
        chk("split low reload", 8'h01, {7'h00, cnt_lo >= 8'hFE});
        wr_reg(8'h91, 8'h00);
    endtask
    task automatic t_cap();
        wr_reg(8'h94, 8'h5A);
        wr_reg(8'h95, 8'hC3);
        wr_reg(8'h91, 8'h10);
        lfo <= 1'b0;
        wait_irq();
        rd_chk("capture low", 8'h92, 8'h5A);
        rd_chk("capture high", 8'h93, 8'hC3);
        wr_reg(8'h91, 8'h00);
        lfo <= 1'b1;
    endtask
    // Phase of the divider is unknown, so one tick either way is allowed
    task automatic t_pace(logic [7:0] c, logic p, int cyc);
        @(posedge clk_in);
        lpick <= p;
        hpick <= p;
        wr_reg(8'h94, 8'h00);
        wr_reg(8'h91, c);
        repeat (cyc) @(posedge clk_in);
        wr_reg(8'h91, 8'h00);
        #1 chk("ten ticks", 8'h01, {7'h00, cnt_lo inside {[8'h09:8'h0B]}});
        // Idle spell lets the stopped-count watcher see a quiet bus
        repeat (20) @(posedge clk_in);
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial forever #5 clk_in = ~clk_in;
    initial begin
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        t_regs();
        t_wrap16();
        t_low16();
        t_split();
        t_cap();
        t_pace(8'h05, 1'b1, 320);
        t_pace(8'h05, 1'b0, 120);
        t_pace(8'h04, 1'b1, 120);
        print_verdict();
    end
    // All scenarios take about 850 cycles; this allows over ten times that
    initial begin
        #100000;
        n_fail++;
        print_verdict();
    end
endmodule // art_timer_tb
bind art_timer art_timer_monitor u_mon (.clk_in, .rst_in, .sfr_addr_in, .sfr_wdata_in,
    .sfr_wr_in, .sfr_rd_in, .timer_irq_enable_in, .irq_out, .counter_low_out,
    .counter_high_out, .sfr_rdata_out);
